/* shared/ufp_pkg.sv */
// package for the usb function address and power control block
package ufp_pkg;
    // register offsets (printed offsets are not all multiples of four: byte addr = 4 * index)
    localparam logic [7:0] FUNC_ADDR_IDX = 8'h00;
    localparam logic [7:0] PWR_CTRL_IDX = 8'h01;
    localparam logic [7:0] EP_INDEX_IDX = 8'h0e;
    localparam logic [7:0] INT_EN_IDX = 8'h07;
    localparam logic [7:0] INT_FLAG_IDX = 8'h02;
    localparam logic [7:0] EP_CSR_IDX = 8'h11;
    localparam logic [11:0] FUNC_ADDR_ADDR = {2'b00, FUNC_ADDR_IDX, 2'b00};
    localparam logic [11:0] PWR_CTRL_ADDR = {2'b00, PWR_CTRL_IDX, 2'b00};
    localparam logic [11:0] EP_INDEX_ADDR = {2'b00, EP_INDEX_IDX, 2'b00};
    localparam logic [11:0] INT_EN_ADDR = {2'b00, INT_EN_IDX, 2'b00};
    localparam logic [11:0] INT_FLAG_ADDR = {2'b00, INT_FLAG_IDX, 2'b00};
    localparam logic [11:0] EP_CSR_ADDR = {2'b00, EP_CSR_IDX, 2'b00};
    // power control field positions and the function address update bit
    localparam int PWR_ISO_BIT = 7;
    localparam int PWR_INH_BIT = 4;
    localparam int PWR_RST_BIT = 3;
    localparam int PWR_RESUME_BIT = 2;
    localparam int PWR_SUSP_BIT = 1;
    localparam int PWR_SUSPEND_DETECT_ENABLE_BIT = 0;
    localparam int FUNCTION_ADDRESS_UPD_BIT = 7;
    // interrupt flag / enable positions
    localparam int IRQ_SUSP_BIT = 0;
    localparam int IRQ_RESUME_BIT = 1;
    localparam int IRQ_RESET_BIT = 2;
    localparam int IRQ_SOF_BIT = 3;
    // reset values
    localparam logic [7:0] FUNC_ADDR_RST = 8'h00;
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [3:0] INT_EN_RST = 4'h6;
    localparam logic [3:0] INT_EN_BUS_RST = 4'he;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

/* rtl/ufp_ctrl.sv */
// usb function address and power control with apb register slave
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module ufp_ctrl #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // bus side events from the serial engine
    input wire logic bus_reset_det_i,
    input wire logic bus_suspend_det_i,
    input wire logic bus_resume_det_i,
    input wire logic sof_rx_i,
    input wire logic transfer_done_i,
    input wire logic iso_in_token_i,
    input wire logic iso_pkt_loaded_i,
    // controls toward the serial engine
    output logic [6:0] active_addr_o,
    output logic ctrl_enable_o,
    output logic resume_drive_o,
    output logic suspend_o,
    output logic osc_wake_o,
    output logic fifo_flush_o,
    output logic iso_send_zlp_o,
    output logic iso_release_o,
    output logic [3:0] int_flags_o
);
    import ufp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic wr_en;
    logic rd_en;
    logic [11:0] addr_w;
    assign addr_w = 12'(paddr_i);
    assign wr_en = psel_i && penable_i && pwrite_i && clk_en_i && pstrb_i[0];
    assign rd_en = psel_i && penable_i && !pwrite_i && clk_en_i;
    // zero wait state slave; the clock enable stretches the access phase
    assign pready_o = clk_en_i;

    function automatic logic is_mapped(input logic [11:0] a);
        return (a == FUNC_ADDR_ADDR) || (a == PWR_CTRL_ADDR) || (a == EP_INDEX_ADDR) ||
               (a == INT_EN_ADDR) || (a == INT_FLAG_ADDR) || (a == EP_CSR_ADDR);
    endfunction

    assign pslverr_o = psel_i && penable_i && !is_mapped(addr_w);

    logic wr_function_address;
    logic wr_pwr;
    logic wr_idx;
    logic wr_ien;
    logic wr_csr;
    logic rd_flags;
    assign wr_function_address = wr_en && (addr_w == FUNC_ADDR_ADDR);
    assign wr_pwr = wr_en && (addr_w == PWR_CTRL_ADDR);
    assign wr_idx = wr_en && (addr_w == EP_INDEX_ADDR);
    assign wr_ien = wr_en && (addr_w == INT_EN_ADDR);
    assign wr_csr = wr_en && (addr_w == EP_CSR_ADDR);
    assign rd_flags = rd_en && (addr_w == INT_FLAG_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // controller reset sources

    // forced reset is taken as a one cycle synchronous pulse so nothing glitches
    logic force_rst;
    logic ctl_rst;
    logic bus_rst;
    logic inhibit_q;
    assign force_rst = wr_pwr && pwdata_i[PWR_RST_BIT];
    assign ctl_rst = sys_rst_i || force_rst;
    // inhibited controller ignores bus reset, bus suspend and the sof irq; transfer done and iso hold still act
    assign bus_rst = clk_en_i && bus_reset_det_i && !inhibit_q;

    logic bus_rst_flag_q;
    logic [6:0] addr_q;
    logic [6:0] active_q;
    logic update_q;
    logic suspend_detect_enable_q;
    logic iso_q;
    logic resume_q;
    logic susp_q;
    logic [7:0] ep_index_q;
    logic [7:0] ep_csr_q;
    logic [3:0] int_en_q;
    logic [3:0] int_flag_q;

    ////////////////////////////////////////////////////////////////////////////
    // inhibit

    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            inhibit_q <= 1'b1;
        end else if (wr_pwr && !pwdata_i[PWR_INH_BIT]) begin
            inhibit_q <= 1'b0;
        end
    end
    assign ctrl_enable_o = !inhibit_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus reset status

    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            bus_rst_flag_q <= 1'b0;
        end else if (clk_en_i) begin
            bus_rst_flag_q <= bus_reset_det_i && !inhibit_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // function address

    always_ff @(posedge clk_i) begin
        if (ctl_rst || bus_rst) begin
            addr_q <= FUNC_ADDR_RST[6:0];
            active_q <= FUNC_ADDR_RST[6:0];
            update_q <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_function_address) begin
                addr_q <= pwdata_i[6:0];
                update_q <= 1'b1;
            end else if (update_q && transfer_done_i) begin
                active_q <= addr_q;
                update_q <= 1'b0;
            end
        end
    end
    assign active_addr_o = active_q;

    ////////////////////////////////////////////////////////////////////////////
    // power control bits

    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            suspend_detect_enable_q <= 1'b0;
            iso_q <= 1'b0;
            resume_q <= 1'b0;
        end else if (wr_pwr) begin
            suspend_detect_enable_q <= pwdata_i[PWR_SUSPEND_DETECT_ENABLE_BIT];
            iso_q <= pwdata_i[PWR_ISO_BIT];
            resume_q <= pwdata_i[PWR_RESUME_BIT];
        end
    end
    assign resume_drive_o = resume_q;

    ////////////////////////////////////////////////////////////////////////////
    // suspend

    logic susp_enter;
    logic susp_exit;
    assign susp_enter = clk_en_i && !inhibit_q && suspend_detect_enable_q && bus_suspend_det_i && !susp_q;
    assign susp_exit = clk_en_i && (bus_resume_det_i || resume_q || bus_reset_det_i);

    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            susp_q <= 1'b0;
        end else if (susp_exit) begin
            susp_q <= 1'b0;
        end else if (susp_enter) begin
            susp_q <= 1'b1;
        end
    end
    assign suspend_o = susp_q;
    assign osc_wake_o = susp_q && (susp_exit || force_rst);

    ////////////////////////////////////////////////////////////////////////////
    // endpoint index and csr

    always_ff @(posedge clk_i) begin
        if (ctl_rst || bus_rst) begin
            ep_index_q <= CSR_RST;
            ep_csr_q <= CSR_RST;
        end else begin
            if (wr_idx) begin
                ep_index_q <= pwdata_i[7:0];
            end
            if (wr_csr) begin
                ep_csr_q <= pwdata_i[7:0];
            end
        end
    end
    assign fifo_flush_o = bus_rst;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt enables and flags

    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            int_en_q <= INT_EN_RST;
        end else if (bus_rst) begin
            int_en_q <= INT_EN_BUS_RST;
        end else if (wr_ien) begin
            int_en_q <= pwdata_i[3:0];
        end
    end

    logic [3:0] ev;
    always_comb begin
        ev = 4'h0;
        ev[IRQ_SUSP_BIT] = susp_enter && int_en_q[IRQ_SUSP_BIT];
        ev[IRQ_RESUME_BIT] = clk_en_i && bus_resume_det_i && susp_q &&
                             int_en_q[IRQ_RESUME_BIT];
        ev[IRQ_RESET_BIT] = bus_rst;
        ev[IRQ_SOF_BIT] = clk_en_i && sof_rx_i && !inhibit_q && int_en_q[IRQ_SOF_BIT];
    end

    // bus reset clears old flags but its own reset event is still raised
    always_ff @(posedge clk_i) begin
        if (ctl_rst) begin
            int_flag_q <= 4'h0;
        end else if (bus_rst) begin
            int_flag_q <= ev;
        end else if (rd_flags) begin
            int_flag_q <= ev; // set wins over read clear
        end else begin
            int_flag_q <= int_flag_q | ev;
        end
    end
    assign int_flags_o = int_flag_q;

    ////////////////////////////////////////////////////////////////////////////
    // iso update: one global hold applies to every iso in endpoint

    logic iso_hold_q;
    always_ff @(posedge clk_i) begin
        if (ctl_rst || bus_rst) begin
            iso_hold_q <= 1'b0;
        end else if (clk_en_i) begin
            if (iso_q && iso_pkt_loaded_i) begin
                iso_hold_q <= 1'b1;
            end else if (sof_rx_i) begin
                iso_hold_q <= 1'b0;
            end
        end
    end
    assign iso_release_o = !iso_hold_q;
    assign iso_send_zlp_o = iso_q && iso_hold_q && iso_in_token_i;

    ////////////////////////////////////////////////////////////////////////////
    // read data

    logic [31:0] rd_d;
    always_comb begin
        rd_d = RD_ZERO;
        case (addr_w)
            FUNC_ADDR_ADDR: begin
                rd_d[6:0] = addr_q;
                rd_d[FUNCTION_ADDRESS_UPD_BIT] = update_q;
            end
            PWR_CTRL_ADDR: begin
                rd_d[PWR_ISO_BIT] = iso_q;
                rd_d[PWR_INH_BIT] = inhibit_q;
                rd_d[PWR_RST_BIT] = bus_rst_flag_q;
                rd_d[PWR_RESUME_BIT] = resume_q;
                rd_d[PWR_SUSP_BIT] = susp_q;
                rd_d[PWR_SUSPEND_DETECT_ENABLE_BIT] = suspend_detect_enable_q;
            end
            EP_INDEX_ADDR: rd_d[7:0] = ep_index_q;
            INT_EN_ADDR: rd_d[3:0] = int_en_q;
            INT_FLAG_ADDR: rd_d[3:0] = int_flag_q;
            EP_CSR_ADDR: rd_d[7:0] = ep_csr_q;
            default: rd_d = RD_ZERO;
        endcase
    end
    assign prdata_o = rd_d;
endmodule // ufp_ctrl

/* verification/ufp_ctrl_properties.sv */
// concurrent checks on the ports of ufp_ctrl
`timescale 1ns/100ps
module ufp_ctrl_properties
    import ufp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic bus_suspend_det_i,
    input wire logic bus_resume_det_i,
    input wire logic sof_rx_i,
    input wire logic transfer_done_i,
    input wire logic iso_in_token_i,
    input wire logic iso_pkt_loaded_i,
    input wire logic [6:0] active_addr_o,
    input wire logic ctrl_enable_o,
    input wire logic resume_drive_o,
    input wire logic suspend_o,
    input wire logic osc_wake_o,
    input wire logic fifo_flush_o,
    input wire logic iso_send_zlp_o,
    input wire logic iso_release_o,
    input wire logic [3:0] int_flags_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // write taken at this edge
    wire logic wr = psel_i && penable_i && pwrite_i && pstrb_i[0] && clk_en_i;
    wire logic pwr_wr = wr && paddr_i == PWR_CTRL_ADDR;
    AST_FLUSH_ADDR: assert property (fifo_flush_o |=> active_addr_o == 7'h00)
        else $error("address not cleared by bus reset");
    AST_RESET_IRQ: assert property (fifo_flush_o |=> int_flags_o[IRQ_RESET_BIT])
        else $error("no reset interrupt flag");
    AST_POR_INHIBIT: assert property (disable iff (1'b0) sys_rst_i |=> !ctrl_enable_o)
        else $error("controller enabled after reset");
    AST_INHIBIT_SET: assert property ($fell(ctrl_enable_o) |-> $past(pwr_wr && pwdata_i[PWR_RST_BIT]))
        else $error("inhibit set without forced reset");
    AST_SUSP_ENTRY: assert property ($rose(suspend_o) |-> $past(bus_suspend_det_i))
        else $error("suspend without bus suspend");
    AST_SUSP_EXIT: assert property (suspend_o && bus_resume_det_i && clk_en_i |=> !suspend_o)
        else $error("suspend held through resume");
    AST_OSC_WAKE: assert property ($fell(suspend_o) |-> $past(osc_wake_o))
        else $error("oscillator not woken");
    AST_ZLP: assert property (iso_send_zlp_o |-> iso_in_token_i && !iso_release_o)
        else $error("zero length packet out of place");
    AST_SOF_RELEASE: assert property (sof_rx_i && clk_en_i && !iso_pkt_loaded_i |=> iso_release_o)
        else $error("iso hold kept past frame start");
    AST_WAKEUP: assert property (pwr_wr && !pwdata_i[PWR_RST_BIT] |=>
        resume_drive_o == $past(pwdata_i[PWR_RESUME_BIT]))
        else $error("resume drive not following wakeup bit");
    AST_ADDR_HOLD: assert property ($changed(active_addr_o) |->
        $past(transfer_done_i || fifo_flush_o || wr))
        else $error("address changed mid transfer");
endmodule // ufp_ctrl_properties

/* verification/ufp_host_model.sv */
// usb host stand-in: turns a command code into bus event lines
`timescale 1ns/100ps
module ufp_host_model (
    input wire logic clk_i,
    input wire logic [2:0] cmd_i,
    output logic bus_reset_det_o,
    output logic bus_suspend_det_o,
    output logic bus_resume_det_o,
    output logic sof_rx_o,
    output logic iso_in_token_o,
    output logic transfer_done_o
);
    // levels last as long as the command, pulses come from one-cycle commands
    always_ff @(posedge clk_i) begin
        bus_reset_det_o <= cmd_i == 3'd1;
        bus_suspend_det_o <= cmd_i == 3'd2;
        bus_resume_det_o <= cmd_i == 3'd3;
        sof_rx_o <= cmd_i == 3'd4;
        iso_in_token_o <= cmd_i == 3'd5;
        transfer_done_o <= cmd_i == 3'd6;
    end
endmodule // ufp_host_model

/* verification/ufp_ctrl_test.sv */
// self-checking bench for ufp_ctrl
`timescale 1ns/100ps
module ufp_ctrl_test;
    import ufp_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, clk_en_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0] pstrb_i = 4'hf, int_flags_o;
    logic pready_o, pslverr_o, err, bus_reset_det_i, bus_suspend_det_i, bus_resume_det_i;
    logic sof_rx_i, transfer_done_i, iso_in_token_i, iso_pkt_loaded_i = 0, flush_seen = 0;
    logic ctrl_enable_o, resume_drive_o, suspend_o, osc_wake_o, fifo_flush_o;
    logic iso_send_zlp_o, iso_release_o;
    logic [6:0] active_addr_o, adr, cur = 7'h00;
    logic [2:0] cmd = 3'd0;
    logic [15:0] lf = 16'h75f2;
    int miscompares = 0, comparisons = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    ufp_ctrl i_ufp_ctrl (.*);
    ufp_host_model i_ufp_host_model (.clk_i(clk_i), .cmd_i(cmd),
        .bus_reset_det_o(bus_reset_det_i), .bus_suspend_det_o(bus_suspend_det_i),
        .bus_resume_det_o(bus_resume_det_i), .sof_rx_o(sof_rx_i),
        .iso_in_token_o(iso_in_token_i), .transfer_done_o(transfer_done_i));
    always @(posedge clk_i) begin
        cyc++;
        if (fifo_flush_o === 1'b1) flush_seen <= 1'b1;
        if (cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; idles one cycle after so the next setup never shares an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // sample just ahead of the edge that completes the access
        @(negedge clk_i);
        while (pready_o !== 1'b1) @(negedge clk_i);
        rd = prdata_o;
        err = pslverr_o;
        @(posedge clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task automatic host(input logic [2:0] c, input int n);
        cmd <= c;
        repeat (n) @(posedge clk_i);
        cmd <= 3'd0;
        @(posedge clk_i);
    endtask
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk("enable", 0, ctrl_enable_o);
        rchk(PWR_CTRL_ADDR, 32'h10);
        rchk(12'hffc, 32'h0);
        chk("slverr", 1, err);
        apb(1'b1, PWR_CTRL_ADDR, 32'h18);
        apb(1'b1, INT_EN_ADDR, 32'h6);
        apb(1'b1, PWR_CTRL_ADDR, 32'h0);
        chk("enable", 1, ctrl_enable_o);
        apb(1'b1, PWR_CTRL_ADDR, 32'h10);
        rchk(PWR_CTRL_ADDR, 32'h0);
        $display("test inhibit done");
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            adr = lf[6:0];
            apb(1'b1, FUNC_ADDR_ADDR, {25'h0, adr});
            rchk(FUNC_ADDR_ADDR, {24'h0, 1'b1, adr});
            chk("active", cur, active_addr_o);
            host(3'd6, 1);
            cur = adr;
            rchk(FUNC_ADDR_ADDR, {25'h0, adr});
            chk("active", cur, active_addr_o);
        end
        $display("test address done");
        apb(1'b1, EP_INDEX_ADDR, {28'h0, lf[3:0] | 4'h1});
        apb(1'b1, EP_CSR_ADDR, {24'h0, lf[15:8] | 8'h1});
        apb(1'b1, INT_EN_ADDR, 32'h1);
        cmd <= 3'd1;
        repeat (2) @(posedge clk_i);
        rchk(PWR_CTRL_ADDR, 32'h08);
        host(3'd0, 1);
        chk("flush", 1, flush_seen);
        chk("flags", 32'h4, int_flags_o);
        rchk(FUNC_ADDR_ADDR, 32'h0);
        rchk(EP_INDEX_ADDR, 32'h0);
        rchk(EP_CSR_ADDR, 32'h0);
        rchk(INT_EN_ADDR, 32'he);
        $display("test bus reset done");
        apb(1'b1, INT_EN_ADDR, 32'hf);
        host(3'd2, 3);
        chk("suspend", 0, suspend_o);
        apb(1'b1, PWR_CTRL_ADDR, 32'h1);
        host(3'd2, 3);
        chk("suspend", 1, suspend_o);
        chk("susp irq", 1, int_flags_o[IRQ_SUSP_BIT]);
        rchk(PWR_CTRL_ADDR, 32'h3);
        host(3'd3, 2);
        chk("suspend", 0, suspend_o);
        chk("resume irq", 1, int_flags_o[IRQ_RESUME_BIT]);
        rchk(PWR_CTRL_ADDR, 32'h1);
        host(3'd2, 3);
        apb(1'b1, PWR_CTRL_ADDR, 32'h5);
        @(posedge clk_i);
        chk("resume drive", 1, resume_drive_o);
        chk("suspend", 0, suspend_o);
        repeat (20) @(posedge clk_i);
        apb(1'b1, PWR_CTRL_ADDR, 32'h1);
        chk("resume drive", 0, resume_drive_o);
        $display("test suspend done");
        apb(1'b1, PWR_CTRL_ADDR, 32'h81);
        iso_pkt_loaded_i <= 1'b1;
        @(posedge clk_i);
        iso_pkt_loaded_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("iso release", 0, iso_release_o);
        cmd <= 3'd5;
        @(posedge clk_i);
        cmd <= 3'd0;
        @(negedge clk_i);
        chk("zlp", 1, iso_send_zlp_o);
        @(posedge clk_i);
        host(3'd4, 1);
        @(posedge clk_i);
        chk("iso release", 1, iso_release_o);
        $display("test iso done");
        // frozen clock enable must ignore bus suspend
        clk_en_i <= 1'b0;
        host(3'd2, 3);
        chk("frozen suspend", 0, suspend_o);
        clk_en_i <= 1'b1;
        @(posedge clk_i);
        $display("test clock enable done");
        apb(1'b1, FUNC_ADDR_ADDR, 32'h55);
        apb(1'b1, PWR_CTRL_ADDR, 32'h08);
        chk("enable", 0, ctrl_enable_o);
        rchk(PWR_CTRL_ADDR, 32'h10);
        rchk(FUNC_ADDR_ADDR, 32'h0);
        rchk(INT_EN_ADDR, 32'h6);
        $display("test forced reset done");
        close_out();
    end
endmodule // ufp_ctrl_test
bind ufp_ctrl ufp_ctrl_properties i_ufp_ctrl_properties (.*);
